// >>> src/pdt_consts.vh
// constants for the three-phase pwm dead-time, pattern and duty-load block
// assumes byte addresses on a 32-bit avalon-mm slave, one word per register
`ifndef PDT_CONSTS_VH
`define PDT_CONSTS_VH

// ==========================================================================
// register byte offsets
`define PDT_OFS_CTRL       8'h00
`define PDT_OFS_DT_RELOAD  8'h04
`define PDT_OFS_DUTY_BUF   8'h08
`define PDT_OFS_DUTY_VAL   8'h14
`define PDT_OFS_MODE_BUF   8'h20
`define PDT_OFS_LEVEL_BUF  8'h24
`define PDT_OFS_MODE_SEL   8'h28
`define PDT_OFS_LEVEL      8'h2c
`define PDT_OFS_LOAD_SW    8'h30
`define PDT_OFS_STATUS     8'h34
`define PDT_OFS_DT_COUNT   8'h38

// ==========================================================================
// field positions
`define PDT_CTRL_MODE_LSB  0
`define PDT_CTRL_DTCLK_LSB 2
`define PDT_LOAD_SWITCH_REGISTER_PATTERN   3
`define PDT_STAT_CMP_LSB   3

// ==========================================================================
// output modes
`define PDT_MODE_OFF       2'h0
`define PDT_MODE_1         2'h1
`define PDT_MODE_2         2'h2
`define PDT_MODE_3         2'h3

// ==========================================================================
// reset values
`define PDT_RST_MODE       2'h1
`define PDT_RST_DTCLK      2'h0
`define PDT_RST_DT_RELOAD  8'h00
`define PDT_RST_DUTY       16'h0000
`define PDT_RST_MODE_SEL   6'h3f
`define PDT_RST_LEVEL      6'h00
`define PDT_DT_IDLE        8'hff
`define PDT_DT_ZERO        8'h00

`endif

// >>> src/pdt_dead_timer.v
// one dead-time down-counter with its one-shot pulse
// assumes tick is a one-cycle enable from a divider on the same clock
`timescale 1ns/1ps
`include "pdt_consts.vh"

module pdt_dead_timer
(
  input  wire       clock,
  input  wire       reset,
  input  wire       enable,
  input  wire       start,
  input  wire       tick,
  input  wire       hold,
  input  wire [7:0] reload,
  output reg  [7:0] count,
  output reg        pulse
);

  // ==========================================================================
  // down-count with one-shot
  // a start wins over counting and hold, so a second comparator change restarts the count
  always @(posedge clock)
  begin
    if (reset || !enable)
    begin
      count <= `PDT_DT_IDLE;
      pulse <= 1'b0;
    end
    else if (start)
    begin
      count <= reload;
      pulse <= 1'b1;
    end
    else if (pulse && tick && !hold)
    begin
      if (count == `PDT_DT_ZERO)
      begin
        count <= `PDT_DT_IDLE;
        pulse <= 1'b0;
      end
      else
      begin
        count <= count - 8'h01;
      end
    end
  end

endmodule // pdt_dead_timer

// >>> src/pdt_pwm_core.v
// dead-time timers, buffered output pattern and duty reload for a 3-phase pwm
// assumes the up/down counter lives outside; its value and run state are inputs
// assumes compare_match comes from a timer on the same clock
//
// Functional notes
// - three dead-time down-counters, one per phase, each giving a one-shot pulse
// - a comparator change starts that phase's timer two clocks later
// - start loads the reload value, raises the pulse, then counts on selected clock
// - pulse ends on underflow from zero; timer then rests at all ones
// - a further comparator change while running reloads and restarts the timer
// - while the pwm counter is stopped a running timer holds its value
// - timers do not run in output mode 2
// - a slow dead-time clock may shorten dead time by one tick less one clock
// - timer 1 serves phase u, 2 serves v, 3 serves w, all alike
// - compare-match falling edge copies both pattern buffers to working registers
// - pins show a new pattern one clock after the pattern registers change
// - software pattern-load bit stays set one clock then clears itself
// - falling edge of the pattern-load bit copies both pattern buffers
// - one self-clearing duty-load bit per phase, high for one clock
// - falling edge of a duty-load bit copies that phase's duty buffer
// - comparator high while counter >= duty; pins follow two clocks later
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "pdt_consts.vh"

module pdt_pwm_core
(
  input  wire        clock,
  input  wire        reset,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire [15:0] pwm_updown_counter,
  input  wire        pwm_counter_running,
  input  wire        compare_match,
  output wire        u_positive_output,
  output wire        u_reverse_output,
  output wire        v_positive_output,
  output wire        v_reverse_output,
  output wire        w_positive_output,
  output wire        w_reverse_output
);

  // ==========================================================================
  // declarations
  reg         ack_reg;
  reg  [1:0]  mode_reg;
  reg  [1:0]  dt_clk_sel_reg;
  reg  [7:0]  dead_time_reload_reg;
  reg  [5:0]  output_mode_select_buffer_reg;
  reg  [5:0]  output_level_pattern_buffer_reg;
  reg  [5:0]  output_mode_select_reg;
  reg  [5:0]  output_level_pattern_reg;
  reg         sw_pattern_load_pulse_reg;
  reg         pattern_pulse_prev_reg;
  reg  [2:0]  sw_duty_load_pulse_reg;
  reg  [2:0]  duty_pulse_prev_reg;
  reg         compare_match_prev_reg;
  reg  [2:0]  dt_div_reg;
  reg  [5:0]  pin_reg;
  reg  [31:0] read_next;
  reg  [2:0]  dt_mask;
  wire        bus_req;
  wire        wr_en;
  wire        pattern_load;
  wire        dt_tick;
  wire        dt_enable;
  wire [47:0] duty_value_flat;
  wire [47:0] duty_buffer_flat;
  wire [23:0] dt_count_flat;
  wire [2:0]  dt_pulse;
  wire [2:0]  cmp_delayed;
  wire [5:0]  pwm_pin;
  wire [5:0]  pin_next;

  // ==========================================================================
  // avalon-mm slave
  // every access takes one wait cycle; read data are captured in that cycle
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_reg;
  assign wr_en           = avs_write & ack_reg;

  // ack toggles so back-to-back requests each get their own wait cycle
  always @(posedge clock)
  begin
    if (reset)
      ack_reg <= 1'b0;
    else
      ack_reg <= bus_req & ~ack_reg;
  end

  // read mux; unmapped addresses read as zero
  always @*
  begin
    read_next = 32'h0000_0000;
    case (avs_address)
      `PDT_OFS_CTRL:
        read_next = {28'h000_0000, dt_clk_sel_reg, mode_reg};
      `PDT_OFS_DT_RELOAD:
        read_next = {24'h00_0000, dead_time_reload_reg};
      `PDT_OFS_DUTY_BUF:
        read_next = {16'h0000, duty_buffer_flat[15:0]};
      `PDT_OFS_DUTY_BUF + 8'h04:
        read_next = {16'h0000, duty_buffer_flat[31:16]};
      `PDT_OFS_DUTY_BUF + 8'h08:
        read_next = {16'h0000, duty_buffer_flat[47:32]};
      `PDT_OFS_DUTY_VAL:
        read_next = {16'h0000, duty_value_flat[15:0]};
      `PDT_OFS_DUTY_VAL + 8'h04:
        read_next = {16'h0000, duty_value_flat[31:16]};
      `PDT_OFS_DUTY_VAL + 8'h08:
        read_next = {16'h0000, duty_value_flat[47:32]};
      `PDT_OFS_MODE_BUF:
        read_next = {26'h000_0000, output_mode_select_buffer_reg};
      `PDT_OFS_LEVEL_BUF:
        read_next = {26'h000_0000, output_level_pattern_buffer_reg};
      `PDT_OFS_MODE_SEL:
        read_next = {26'h000_0000, output_mode_select_reg};
      `PDT_OFS_LEVEL:
        read_next = {26'h000_0000, output_level_pattern_reg};
      `PDT_OFS_LOAD_SW:
        read_next = {28'h000_0000, sw_pattern_load_pulse_reg, sw_duty_load_pulse_reg};
      `PDT_OFS_STATUS:
        read_next = {26'h000_0000, cmp_delayed, dt_pulse};
      `PDT_OFS_DT_COUNT:
        read_next = {8'h00, dt_count_flat};
      default:
        read_next = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle, so they stand at the accepting edge
  always @(posedge clock)
  begin
    if (reset)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !ack_reg)
      avs_readdata <= read_next;
  end

  // ==========================================================================
  // control and buffer registers
  // byte lane 0 carries every narrow field
  always @(posedge clock)
  begin
    if (reset)
    begin
      mode_reg                        <= `PDT_RST_MODE;
      dt_clk_sel_reg                  <= `PDT_RST_DTCLK;
      dead_time_reload_reg            <= `PDT_RST_DT_RELOAD;
      output_mode_select_buffer_reg   <= `PDT_RST_MODE_SEL;
      output_level_pattern_buffer_reg <= `PDT_RST_LEVEL;
    end
    else if (wr_en && avs_byteenable[0])
    begin
      case (avs_address)
        `PDT_OFS_CTRL:
        begin
          mode_reg       <= avs_writedata[`PDT_CTRL_MODE_LSB +: 2];
          dt_clk_sel_reg <= avs_writedata[`PDT_CTRL_DTCLK_LSB +: 2];
        end
        `PDT_OFS_DT_RELOAD:
          dead_time_reload_reg <= avs_writedata[7:0];
        `PDT_OFS_MODE_BUF:
          output_mode_select_buffer_reg <= avs_writedata[5:0];
        `PDT_OFS_LEVEL_BUF:
          output_level_pattern_buffer_reg <= avs_writedata[5:0];
        default:
          mode_reg <= mode_reg;
      endcase
    end
  end

  // ==========================================================================
  // self-clearing load bits
  // a written one lives exactly one clock; the 1-wait bus cannot rewrite sooner
  always @(posedge clock)
  begin
    if (reset)
    begin
      sw_pattern_load_pulse_reg <= 1'b0;
      sw_duty_load_pulse_reg    <= 3'h0;
      pattern_pulse_prev_reg    <= 1'b0;
      duty_pulse_prev_reg       <= 3'h0;
      compare_match_prev_reg    <= 1'b0;
    end
    else
    begin
      if (wr_en && avs_byteenable[0] && avs_address == `PDT_OFS_LOAD_SW)
      begin
        sw_pattern_load_pulse_reg <= avs_writedata[`PDT_LOAD_SWITCH_REGISTER_PATTERN];
        sw_duty_load_pulse_reg    <= avs_writedata[2:0];
      end
      else
      begin
        sw_pattern_load_pulse_reg <= 1'b0;
        sw_duty_load_pulse_reg    <= 3'h0;
      end
      pattern_pulse_prev_reg <= sw_pattern_load_pulse_reg;
      duty_pulse_prev_reg    <= sw_duty_load_pulse_reg;
      compare_match_prev_reg <= compare_match;
    end
  end

  // ==========================================================================
  // output pattern working registers
  // hardware and software triggers share one load; coincident edges load once
  assign pattern_load = (compare_match_prev_reg & ~compare_match)
                      | (pattern_pulse_prev_reg & ~sw_pattern_load_pulse_reg);

  always @(posedge clock)
  begin
    if (reset)
    begin
      output_mode_select_reg   <= `PDT_RST_MODE_SEL;
      output_level_pattern_reg <= `PDT_RST_LEVEL;
    end
    else if (pattern_load)
    begin
      output_mode_select_reg   <= output_mode_select_buffer_reg;
      output_level_pattern_reg <= output_level_pattern_buffer_reg;
    end
  end

  // ==========================================================================
  // dead-time clock divider
  // free running and not aligned to a timer start, so the first tick may come
  // early and the dead time can fall short by up to one tick less one clock
  always @*
  begin
    case (dt_clk_sel_reg)
      2'h0:    dt_mask = 3'h0;
      2'h1:    dt_mask = 3'h1;
      2'h2:    dt_mask = 3'h3;
      default: dt_mask = 3'h7;
    endcase
  end

  always @(posedge clock)
  begin
    if (reset)
      dt_div_reg <= 3'h0;
    else
      dt_div_reg <= dt_div_reg + 3'h1;
  end

  assign dt_tick   = ((dt_div_reg & dt_mask) == dt_mask);
  assign dt_enable = (mode_reg != `PDT_MODE_2);

  // ==========================================================================
  // per-phase comparator, duty registers, dead-time timer and pin pair
  genvar ph;
  generate
    for (ph = 0; ph < 3; ph = ph + 1)
    begin : phase
      reg  [15:0] phase_duty_buffer_reg;
      reg  [15:0] phase_duty_value_reg;
      reg         cmp_d1_reg;
      reg         cmp_d2_reg;
      wire        dt_start;
      wire        dt_block;
      wire        pwm_on;
      wire [7:0]  byte_addr;
      localparam integer PH_OFS = 4 * ph;   // one word per phase

      assign byte_addr = `PDT_OFS_DUTY_BUF + PH_OFS[7:0];

      // duty buffer write and falling-edge load into the active duty
      always @(posedge clock)
      begin
        if (reset)
        begin
          phase_duty_buffer_reg <= `PDT_RST_DUTY;
          phase_duty_value_reg  <= `PDT_RST_DUTY;
        end
        else
        begin
          if (wr_en && avs_address == byte_addr)
          begin
            if (avs_byteenable[0])
              phase_duty_buffer_reg[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
              phase_duty_buffer_reg[15:8] <= avs_writedata[15:8];
          end
          if (duty_pulse_prev_reg[ph] && !sw_duty_load_pulse_reg[ph])
            phase_duty_value_reg <= phase_duty_buffer_reg;
        end
      end

      // comparator delayed one clock here, one more in the pin register
      always @(posedge clock)
      begin
        if (reset)
        begin
          cmp_d1_reg <= 1'b0;
          cmp_d2_reg <= 1'b0;
        end
        else
        begin
          cmp_d1_reg <= (pwm_updown_counter >= phase_duty_value_reg);
          cmp_d2_reg <= cmp_d1_reg;
        end
      end

      // timer loads at the same edge that the pins see the change
      assign dt_start = dt_enable & (cmp_d1_reg ^ cmp_d2_reg);

      pdt_dead_timer u_timer
      (
        .clock  (clock),
        .reset  (reset),
        .enable (dt_enable),
        .start  (dt_start),
        .tick   (dt_tick),
        .hold   (~pwm_counter_running),
        .reload (dead_time_reload_reg),
        .count  (dt_count_flat[8*ph +: 8]),
        .pulse  (dt_pulse[ph])
      );

      // start is folded in so the turning-on side never sees a gap cycle
      assign dt_block = dt_pulse[ph] | dt_start;
      assign pwm_on   = cmp_d1_reg;

      // even pin is positive, odd pin is reverse
      assign pwm_pin[2*ph]   = (mode_reg == `PDT_MODE_1) ? (pwm_on & ~dt_block)
                             : (mode_reg == `PDT_MODE_2) ? pwm_on
                             : (mode_reg == `PDT_MODE_3) ? (pwm_on & ~dt_block)
                             : 1'b0;
      assign pwm_pin[2*ph+1] = (mode_reg == `PDT_MODE_1) ? (~pwm_on & ~dt_block)
                             : (mode_reg == `PDT_MODE_2) ? pwm_on
                             : (mode_reg == `PDT_MODE_3) ? (pwm_on & ~dt_block)
                             : 1'b0;

      assign duty_value_flat[16*ph +: 16]  = phase_duty_value_reg;
      assign duty_buffer_flat[16*ph +: 16] = phase_duty_buffer_reg;
      assign cmp_delayed[ph]               = cmp_d1_reg;
    end
  endgenerate

  // ==========================================================================
  // pin register
  // a selected bit passes pwm, a clear bit passes the level pattern
  assign pin_next = (output_mode_select_reg & pwm_pin)
                  | (~output_mode_select_reg & output_level_pattern_reg);

  always @(posedge clock)
  begin
    if (reset)
      pin_reg <= 6'h00;
    else
      pin_reg <= pin_next;
  end

  assign u_positive_output = pin_reg[0];
  assign u_reverse_output  = pin_reg[1];
  assign v_positive_output = pin_reg[2];
  assign v_reverse_output  = pin_reg[3];
  assign w_positive_output = pin_reg[4];
  assign w_reverse_output  = pin_reg[5];

endmodule // pdt_pwm_core

// >>> bench/pdt_motor_side.sv
// model of the compare-match timer and the pwm up/down counter
// assumes the bench calls its tasks; outputs change just after a rising edge
`timescale 1ns/1ps

module pdt_motor_side
(
  input  wire logic        clock,
  output logic      [15:0] pwm_updown_counter,
  output logic             pwm_counter_running,
  output logic             compare_match
);
  // ==========================================================================
  // idle state: counter stopped at zero, no match
  initial
  begin
    pwm_updown_counter = 16'h0000;
    pwm_counter_running = 1'b0;
    compare_match = 1'b0;
  end

  // counter value and run state, as the real counter would present them
  task automatic set_count(input logic [15:0] v, input logic r);
    @(posedge clock);
    pwm_updown_counter <= v;
    pwm_counter_running <= r;
  endtask

  // match pulse; a wide pulse mimics a divided free-running timer clock
  task automatic cm_pulse(input int w);
    @(posedge clock);
    compare_match <= 1'b1;
    repeat (w) @(posedge clock);
    compare_match <= 1'b0;
  endtask
endmodule // pdt_motor_side

// >>> bench/pdt_core_sva.sv
// checker for the pins and register bus of pdt_pwm_core
// assumes full byte enables and no counter-driven duty reloads
`timescale 1ns/1ps
`include "pdt_consts.vh"

module pdt_core_sva
(
  input wire        clock,
  input wire        reset,
  input wire [7:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        compare_match,
  input wire        u_positive_output,
  input wire        u_reverse_output,
  input wire        v_positive_output,
  input wire        v_reverse_output,
  input wire        w_positive_output,
  input wire        w_reverse_output
);
  wire        wa = avs_write && !avs_waitrequest;
  wire        ra = avs_read && !avs_waitrequest;
  wire [5:0]  pins = {w_reverse_output, w_positive_output, v_reverse_output,
                      v_positive_output, u_reverse_output, u_positive_output};
  reg  [5:0]  mb_reg;
  reg  [5:0]  lb_reg;
  reg  [1:0]  mode_reg;
  reg  [15:0] du_reg;
  reg  [15:0] dv_reg;
  reg  [1:0]  ld_reg;

  // ==========================================================================
  // shadows of written values; the duty copy lands two edges after the write
  always @(posedge clock)
  begin
    if (reset)
    begin
      mb_reg <= `PDT_RST_MODE_SEL;
      lb_reg <= `PDT_RST_LEVEL;
      mode_reg <= `PDT_RST_MODE;
      du_reg <= `PDT_RST_DUTY;
      dv_reg <= `PDT_RST_DUTY;
      ld_reg <= 2'h0;
    end
    else
    begin
      if (wa && avs_address == `PDT_OFS_MODE_BUF) mb_reg <= avs_writedata[5:0];
      if (wa && avs_address == `PDT_OFS_LEVEL_BUF) lb_reg <= avs_writedata[5:0];
      if (wa && avs_address == `PDT_OFS_CTRL) mode_reg <= avs_writedata[1:0];
      if (wa && avs_address == `PDT_OFS_DUTY_BUF) du_reg <= avs_writedata[15:0];
      ld_reg <= {ld_reg[0], wa && avs_address == `PDT_OFS_LOAD_SW && avs_writedata[0]};
      if (ld_reg[1]) dv_reg <= du_reg;
    end
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_cm_load;
    $fell(compare_match) && mb_reg == 6'h00 |-> ##2 pins == lb_reg;
  endproperty
  a_cm_load: assert property (p_cm_load) else $error("match load late or wrong");
  property p_sw_load;
    wa && avs_address == `PDT_OFS_LOAD_SW && avs_writedata[3] && mb_reg == 6'h00
      |-> ##4 pins == lb_reg;
  endproperty
  a_sw_load: assert property (p_sw_load) else $error("soft load late or wrong");
  property p_load_clear;
    ra && avs_address == `PDT_OFS_LOAD_SW |-> avs_readdata[3:0] == 4'h0;
  endproperty
  a_load_clear: assert property (p_load_clear) else $error("load bit stuck");
  property p_width;
    ra && (avs_address == `PDT_OFS_MODE_SEL || avs_address == `PDT_OFS_LEVEL)
      |-> avs_readdata[31:6] == 26'h0;
  endproperty
  a_width: assert property (p_width) else $error("pattern wider than six");
  property p_duty_copy;
    ra && avs_address == `PDT_OFS_DUTY_VAL |-> avs_readdata == {16'h0, $past(dv_reg)};
  endproperty
  a_duty_copy: assert property (p_duty_copy) else $error("duty copy wrong");
  property p_mode2_stat;
    ra && avs_address == `PDT_OFS_STATUS && mode_reg == `PDT_MODE_2
      && $past(mode_reg, 4) == `PDT_MODE_2 |-> avs_readdata[2:0] == 3'h0;
  endproperty
  a_mode2_stat: assert property (p_mode2_stat) else $error("pulse in mode 2");
  property p_mode2_idle;
    ra && avs_address == `PDT_OFS_DT_COUNT && mode_reg == `PDT_MODE_2
      && $past(mode_reg, 4) == `PDT_MODE_2 |-> avs_readdata[23:0] == 24'hffffff;
  endproperty
  a_mode2_idle: assert property (p_mode2_idle) else $error("timer runs in mode 2");
  property p_no_overlap;
    mode_reg == `PDT_MODE_1 && $past(mode_reg) == `PDT_MODE_1
      |-> (pins & {pins[4], pins[5], pins[2], pins[3], pins[0], pins[1]}) == 6'h00;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("pair overlaps");

  c_match: cover property ($fell(compare_match));
  c_soft: cover property (wa && avs_address == `PDT_OFS_LOAD_SW && avs_writedata[3]);
  c_mode2: cover property (ra && mode_reg == `PDT_MODE_2);
endmodule // pdt_core_sva

bind pdt_pwm_core pdt_core_sva u_sva
(
  .clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .compare_match(compare_match),
  .u_positive_output(u_positive_output), .u_reverse_output(u_reverse_output),
  .v_positive_output(v_positive_output), .v_reverse_output(v_reverse_output),
  .w_positive_output(w_positive_output), .w_reverse_output(w_reverse_output)
);

// >>> bench/pdt_pwm_core_bench.sv
// bench for the pwm dead-time, pattern and duty-load core
// assumes pdt_motor_side stands in for the counter and compare-match timer
`timescale 1ns/1ps
`include "pdt_consts.vh"

module pdt_pwm_core_bench;
  logic        clock          = 1'b0;
  logic        reset          = 1'b1;
  logic [7:0]  avs_address    = 8'h00;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire  [15:0] cnt;
  wire         run;
  wire         cm;
  wire  [5:0]  pins;
  logic [31:0] rd;
  logic [31:0] n;
  int          fail_count     = 0;
  int          check_count    = 0;
  int          cycles         = 0;
  logic [1:0]  mseq [4]       = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [1:0]  pexp [4]       = '{2'h0, 2'h1, 2'h3, 2'h3};

  pdt_pwm_core dut
  (
    .clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pwm_updown_counter(cnt),
    .pwm_counter_running(run), .compare_match(cm),
    .u_positive_output(pins[0]), .u_reverse_output(pins[1]),
    .v_positive_output(pins[2]), .v_reverse_output(pins[3]),
    .w_positive_output(pins[4]), .w_reverse_output(pins[5])
  );

  pdt_motor_side m
  (
    .clock(clock), .pwm_updown_counter(cnt), .pwm_counter_running(run),
    .compare_match(cm)
  );

  // ==========================================================================
  // clock and hang guard; the tests need under 2000 cycles
  always #12.5 clock = ~clock;

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      complete_run();
    end
  end

  // ==========================================================================
  // tasks
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // one bus transfer; the edge in front keeps release and raise apart
  // waitrequest is sampled at the rising edge; read data are taken at that edge
  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !is_wr;
    avs_write <= is_wr;
    do
      @(posedge clock);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // ==========================================================================
  // test sequence
  initial
  begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rdc(`PDT_OFS_CTRL, 32'h1);
    rdc(`PDT_OFS_MODE_SEL, 32'h3f);
    rdc(8'h3c, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      wr(`PDT_OFS_DUTY_BUF + 8'(i * 4), 32'ha5a0 + i);
      rdc(`PDT_OFS_DUTY_VAL + 8'(i * 4), 32'h0);
      wr(`PDT_OFS_LOAD_SW, 32'h1 << i);
      rdc(`PDT_OFS_LOAD_SW, 32'h0);
      rdc(`PDT_OFS_DUTY_VAL + 8'(i * 4), 32'ha5a0 + i);
    end
    // software pattern load to level outputs
    wr(`PDT_OFS_MODE_BUF, 32'h0);
    wr(`PDT_OFS_LEVEL_BUF, 32'h15);
    rdc(`PDT_OFS_MODE_SEL, 32'h3f);
    wr(`PDT_OFS_LOAD_SW, 32'h8);
    repeat (4) @(negedge clock);
    check({26'h0, pins}, 32'h15);
    rdc(`PDT_OFS_LOAD_SW, 32'h0);
    rdc(`PDT_OFS_MODE_SEL, 32'h0);
    // compare-match loads, short and long match pulses
    for (int i = 0; i < 2; i++)
    begin
      n = i ? 32'h15 : 32'h2a;
      wr(`PDT_OFS_LEVEL_BUF, n);
      m.cm_pulse(1 + 3 * i);
      repeat (4) @(negedge clock);
      check({26'h0, pins}, n);
      rdc(`PDT_OFS_LEVEL, n);
    end
    // pwm on all pins, dead-time reload of five (six ticks) on phase u
    wr(`PDT_OFS_MODE_BUF, 32'h3f);
    wr(`PDT_OFS_LOAD_SW, 32'h8);
    wr(`PDT_OFS_DT_RELOAD, 32'h5);
    wr(`PDT_OFS_DUTY_BUF, 32'h10);
    wr(`PDT_OFS_LOAD_SW, 32'h1);
    m.set_count(16'h0f, 1'b1);
    repeat (20) @(negedge clock);
    check({30'h0, pins[1:0]}, 32'h2);
    m.set_count(16'h10, 1'b1);
    n = 0;
    while (pins[1] !== 1'b0)
    begin
      @(negedge clock);
      n++;
    end
    check(n, 32'h3);
    n = 0;
    while (pins[0] !== 1'b1)
    begin
      @(negedge clock);
      n++;
    end
    check(n, 32'h7);
    // stopping the counter freezes a running timer
    wr(`PDT_OFS_DT_RELOAD, 32'h40);
    m.set_count(16'h0f, 1'b1);
    m.set_count(16'h0f, 1'b0);
    bus(1'b0, `PDT_OFS_DT_COUNT, 32'h0);
    n = rd;
    rdc(`PDT_OFS_DT_COUNT, n);
    check(n & 32'hffffff00, 32'h00ffff00);
    check(n, 32'h00ffff40);
    // a further comparator change reloads a running timer
    wr(`PDT_OFS_DT_RELOAD, 32'h30);
    m.set_count(16'h10, 1'b0);
    repeat (2) @(posedge clock);
    rdc(`PDT_OFS_DT_COUNT, 32'h00ffff30);
    rdc(`PDT_OFS_STATUS, 32'h9);
    m.set_count(16'h0f, 1'b1);
    repeat (80) @(posedge clock);
    rdc(`PDT_OFS_DT_COUNT, 32'h00ffffff);
    // dead-time clock at a quarter rate, three ticks of dead time
    wr(`PDT_OFS_CTRL, 32'h9);
    wr(`PDT_OFS_DT_RELOAD, 32'h2);
    m.set_count(16'h10, 1'b1);
    n = 0;
    while (pins[0] !== 1'b1)
    begin
      @(negedge clock);
      n++;
    end
    check({31'h0, n >= 32'd13 && n <= 32'd16}, 32'h1);
    // every output mode with the comparator steady high
    wr(`PDT_OFS_DT_RELOAD, 32'h5);
    m.set_count(16'h10, 1'b1);
    repeat (20) @(posedge clock);
    for (int i = 0; i < 4; i++)
    begin
      wr(`PDT_OFS_CTRL, {30'h0, mseq[i]});
      repeat (3) @(negedge clock);
      check({30'h0, pins[1:0]}, {30'h0, pexp[i]});
    end
    m.set_count(16'h0f, 1'b1);
    repeat (4) @(posedge clock);
    rdc(`PDT_OFS_STATUS, 32'h0);
    rdc(`PDT_OFS_DT_COUNT, 32'h00ffffff);
    complete_run();
  end
endmodule // pdt_pwm_core_bench
